// *** rtl/tps_consts.svh ***
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH
// register byte offsets
`define TPS_OFS_CTRL 8'h00
`define TPS_OFS_STATUS 8'h04
`define TPS_OFS_START 8'h08
`define TPS_OFS_LOOP_BEGIN 8'h0c
`define TPS_OFS_LOOP_END 8'h10
`define TPS_OFS_LAST 8'h14
`define TPS_OFS_MINOR_CNT 8'h18
`define TPS_OFS_MAJOR_CNT 8'h1c
`define TPS_OFS_IGNORE 8'h20
`define TPS_OFS_SYNC_ADDR 8'h24
`define TPS_OFS_CUR_ADDR 8'h28
`define TPS_OFS_FAIL_REG 8'h2c
`define TPS_OFS_FAIL_BUF 8'h30
`define TPS_OFS_DIR_A 8'h34
`define TPS_OFS_DIR_B 8'h38
`define TPS_OFS_MASK_A 8'h3c
`define TPS_OFS_MASK_B 8'h40
`define TPS_OFS_MEM_ADDR 8'h44
`define TPS_OFS_FUNC_DATA 8'h48
`define TPS_OFS_PERIOD 8'h4c
`define TPS_OFS_MATCH_LIM 8'h50
// control register fields
`define TPS_CTRL_START 0
`define TPS_CTRL_CONT 1
`define TPS_CTRL_MOM 2
`define TPS_CTRL_MATCH 3
`define TPS_CTRL_SYNC 4
`define TPS_CTRL_EXTCLK 5
`define TPS_CTRL_OTF 6
`define TPS_CTRL_CHAIN 9:8
`define TPS_CTRL_DEPTH 11:10
`define TPS_CTRL_STOP 12
// pattern word fields
`define TPS_WORD_DATA 7:0
`define TPS_WORD_DIR_SEL 8
`define TPS_WORD_MASK_SEL 9
// sizes, reset values and timing
`define TPS_MEM_WORDS 4096
`define TPS_BASE_DEPTH 13'h0100
`define TPS_DEPTH_RST 2'h2
`define TPS_CLK_HZ 20000000
`define TPS_TEST_RATE_HZ 10000000
`define TPS_DIV_RST (`TPS_CLK_HZ / `TPS_TEST_RATE_HZ)
`define TPS_MATCH_LIM_RST 16'h0fff
`endif

// *** rtl/tps_pkg.sv ***
package tps_pkg;
  typedef enum logic [1:0] {
    TPS_IDLE = 2'b00,
    TPS_RUN = 2'b01,
    TPS_MATCH = 2'b11
  } tps_state_e;
  typedef logic [11:0] tps_addr_t;
  typedef logic [12:0] tps_count_t;
  typedef logic [7:0] tps_pins_t;
  typedef logic [9:0] tps_word_t;
endpackage : tps_pkg

// *** rtl/tps_period_gen.sv ***
`timescale 1ns/100ps
module tps_period_gen (
  input logic CLK,
  input logic RESET_N,
  input logic RUN_EN,
  input logic EXT_MODE,
  input logic EXT_TRIG,
  input logic [15:0] DIV,
  output logic TICK
);
  logic trig_m_r;
  logic trig_s_r;
  logic trig_d_r;
  logic [15:0] cnt_r;
  //////////////////////////////////////////////////////////////////////////
  // external trigger is asynchronous, so two flops before the edge detect
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
      trig_d_r <= 1'b0;
    end
    else
    begin
      trig_m_r <= EXT_TRIG;
      trig_s_r <= trig_m_r;
      trig_d_r <= trig_s_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      cnt_r <= 16'h0000;
      TICK <= 1'b0;
    end
    else if (!RUN_EN)
    begin
      cnt_r <= 16'h0000;
      TICK <= 1'b0;
    end
    else if (EXT_MODE)
    begin
      TICK <= trig_s_r & ~trig_d_r; // R17
      cnt_r <= 16'h0000;
    end
    else if (cnt_r == 16'h0000)
    begin
      TICK <= 1'b1;
      cnt_r <= (DIV == 16'h0000) ? 16'h0000 : DIV - 16'h0001;
    end
    else
    begin
      TICK <= 1'b0;
      cnt_r <= cnt_r - 16'h0001;
    end
  end
endmodule : tps_period_gen

// *** rtl/tps_sequencer.sv ***
// Notes on behaviour
// R01: pattern words are read one by one from start address up to last address.
// R02: at last address branch to zero while major count remains, repeating major loop.
// R03: minor loop runs from loop-begin to loop-end, minor count times.
// R04: all addresses and both counts are host registers; counts accept up to 4096.
// R05: minor loop lies fully inside or fully outside the major loop.
// R06: at final memory word that is not last address, wrap to zero.
// R07: last address with major count zero stops, idle, flags pass.
// R08: unignored failure above threshold stops, flags fail, keeps address and fail pattern.
// R09: continuous mode loops minor loop forever, counters untouched, until host clears it.
// R10: host may read and write pattern memory while the loop runs.
// R11: momentary with continuous: at loop-end go to next word, then normal.
// R12: host keeps last address different from loop-end when using momentary.
// R13: match mode loops minor loop while failing; first pass exits to zero.
// R14: match timer expiring before any pass reports match failure.
// R15: sync mode pulses the sync output when the sync address executes.
// R16: sync mode suppresses failures at addresses up to and including sync address.
// R17: external clock mode takes each test period from an external trigger.
// R18: chaining gives two or four times depth, barred while sequence processor runs.
// R19: fail data captured in fail register, then copied to the host buffer.
// R20: each host access carries register address and read or write direction.
// R21: per-word direction bit selects which of two direction registers is active.
// R22: per-word mask bit selects which of two mask registers is active.
// R23: only pins with mask bit one are recorded in the fail register.
// R24: host write to functional data address stores the word in pattern memory.
// R25: loop counters decrement per traversal; loop taken only while counter non-zero.
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "tps_consts.svh"
module tps_sequencer (
  input logic CLK,
  input logic RESET_N,
  input logic [7:0] AVS_ADDRESS,
  input logic AVS_READ,
  input logic AVS_WRITE,
  input logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input tps_pkg::tps_pins_t PIN_SENSE,
  output tps_pkg::tps_pins_t PIN_DRIVE,
  output tps_pkg::tps_pins_t PIN_DRIVE_EN,
  input logic EXT_PERIOD_IN,
  output logic SYNC_OUT
);
  import tps_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs; // R20
  endfunction : hit

  // last word of the memory as configured; chaining is dropped when the
  // on-the-fly sequence processor owns the memory
  function automatic tps_addr_t mem_top(input logic [1:0] d, input logic [1:0] c,
                                        input logic otf);
    logic [1:0] dd;
    logic [1:0] cc;
    logic [12:0] words;
    dd = (d == 2'h3) ? 2'h2 : d;
    cc = otf ? 2'h0 : ((c == 2'h3) ? 2'h2 : c); // R18
    words = (`TPS_BASE_DEPTH << dd) << cc;
    return tps_addr_t'(words - 13'h0001);
  endfunction : mem_top

  function automatic tps_addr_t step(input tps_addr_t a, input tps_addr_t top);
    return (a == top) ? 12'h000 : a + 12'h001; // R06
  endfunction : step

  logic ack_r;
  logic req;
  logic wr_en;
  logic [31:0] wd;
  logic [31:0] rd_mux;
  logic cont_r, mom_r, match_r, sync_r, ext_r, otf_r;
  logic [1:0] chain_r, depth_r;
  tps_addr_t start_r, jb_r, ke_r, last_r, ignore_r, sync_addr_r, mem_addr_r;
  tps_count_t minor_cfg_r, major_cfg_r, minor_r, major_r;
  tps_pins_t dir_a_r, dir_b_r, mask_a_r, mask_b_r;
  logic [15:0] div_r, match_lim_r, match_tmr_r;
  tps_word_t mem [0:`TPS_MEM_WORDS-1];
  tps_state_e state_r;
  tps_addr_t cur_r, top;
  logic pass_r, fail_r, mfail_r;
  tps_pins_t sense_m_r, sense_s_r, fail_reg_r, fail_buf_r;
  logic fail_col_r;
  logic tick, go, start_p, stop_p, in_match;
  tps_word_t word;
  tps_pins_t dir_act, mask_act, cmp;
  logic raw_fail, fail_masked, at_last, at_end, at_begin;
  logic br_fail, br_mexp, br_mpass, br_cont, br_mom, br_last, br_minor, br_exit;
  logic mom_clr, match_clr;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access keeps read data registered
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign wr_en = AVS_WRITE & ack_r;
  assign wd = AVS_WRITEDATA;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_comb
  begin
    case (AVS_ADDRESS)
      `TPS_OFS_CTRL: rd_mux = {19'h0, 1'b0, depth_r, chain_r, 1'b0, otf_r, ext_r, sync_r,
                               match_r, mom_r, cont_r, 1'b0};
      `TPS_OFS_STATUS: rd_mux = {28'h0, mfail_r, fail_r, pass_r, state_r != TPS_IDLE};
      `TPS_OFS_START: rd_mux = 32'(start_r);
      `TPS_OFS_LOOP_BEGIN: rd_mux = 32'(jb_r);
      `TPS_OFS_LOOP_END: rd_mux = 32'(ke_r);
      `TPS_OFS_LAST: rd_mux = 32'(last_r);
      `TPS_OFS_MINOR_CNT: rd_mux = 32'(minor_cfg_r);
      `TPS_OFS_MAJOR_CNT: rd_mux = 32'(major_cfg_r);
      `TPS_OFS_IGNORE: rd_mux = 32'(ignore_r);
      `TPS_OFS_SYNC_ADDR: rd_mux = 32'(sync_addr_r);
      `TPS_OFS_CUR_ADDR: rd_mux = 32'(cur_r); // R08
      `TPS_OFS_FAIL_REG: rd_mux = 32'(fail_reg_r);
      `TPS_OFS_FAIL_BUF: rd_mux = 32'(fail_buf_r); // R19
      `TPS_OFS_DIR_A: rd_mux = 32'(dir_a_r);
      `TPS_OFS_DIR_B: rd_mux = 32'(dir_b_r);
      `TPS_OFS_MASK_A: rd_mux = 32'(mask_a_r);
      `TPS_OFS_MASK_B: rd_mux = 32'(mask_b_r);
      `TPS_OFS_MEM_ADDR: rd_mux = 32'(mem_addr_r);
      `TPS_OFS_FUNC_DATA: rd_mux = 32'(mem[mem_addr_r]); // R10
      `TPS_OFS_PERIOD: rd_mux = 32'(div_r);
      `TPS_OFS_MATCH_LIM: rd_mux = 32'(match_lim_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ & ~ack_r)
      AVS_READDATA <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      start_r <= 12'h000;
      jb_r <= 12'h000;
      ke_r <= 12'h000;
      last_r <= 12'h000;
      minor_cfg_r <= 13'h0000;
      major_cfg_r <= 13'h0000;
      ignore_r <= 12'h000;
      sync_addr_r <= 12'h000;
      dir_a_r <= 8'h00;
      dir_b_r <= 8'h00;
      mask_a_r <= 8'h00;
      mask_b_r <= 8'h00;
      div_r <= 16'(`TPS_DIV_RST);
      match_lim_r <= `TPS_MATCH_LIM_RST;
    end
    else if (wr_en)
    begin
      if (hit(AVS_ADDRESS, `TPS_OFS_START)) start_r <= wd[11:0]; // R04
      if (hit(AVS_ADDRESS, `TPS_OFS_LOOP_BEGIN)) jb_r <= wd[11:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_LOOP_END)) ke_r <= wd[11:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_LAST)) last_r <= wd[11:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_MINOR_CNT)) minor_cfg_r <= wd[12:0]; // R04
      if (hit(AVS_ADDRESS, `TPS_OFS_MAJOR_CNT)) major_cfg_r <= wd[12:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_IGNORE)) ignore_r <= wd[11:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_SYNC_ADDR)) sync_addr_r <= wd[11:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_DIR_A)) dir_a_r <= wd[7:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_DIR_B)) dir_b_r <= wd[7:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_MASK_A)) mask_a_r <= wd[7:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_MASK_B)) mask_b_r <= wd[7:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_PERIOD)) div_r <= wd[15:0];
      if (hit(AVS_ADDRESS, `TPS_OFS_MATCH_LIM)) match_lim_r <= wd[15:0];
    end
  end

  // mode bits: a host write wins over the hardware clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      {cont_r, mom_r, match_r, sync_r, ext_r, otf_r} <= 6'h00;
      chain_r <= 2'h0;
      depth_r <= `TPS_DEPTH_RST;
    end
    else if (wr_en && hit(AVS_ADDRESS, `TPS_OFS_CTRL))
    begin
      cont_r <= wd[`TPS_CTRL_CONT]; // R09
      mom_r <= wd[`TPS_CTRL_MOM];
      match_r <= wd[`TPS_CTRL_MATCH];
      sync_r <= wd[`TPS_CTRL_SYNC];
      ext_r <= wd[`TPS_CTRL_EXTCLK];
      otf_r <= wd[`TPS_CTRL_OTF];
      chain_r <= wd[`TPS_CTRL_CHAIN];
      depth_r <= wd[`TPS_CTRL_DEPTH];
    end
    else
    begin
      if (mom_clr)
      begin
        mom_r <= 1'b0; // R11
        cont_r <= 1'b0;
      end
      if (match_clr)
        match_r <= 1'b0; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern memory; host port stays open while the sequencer runs
  always_ff @(posedge CLK)
  begin
    if (wr_en && hit(AVS_ADDRESS, `TPS_OFS_FUNC_DATA))
      mem[mem_addr_r] <= wd[9:0]; // R24 R10
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      mem_addr_r <= 12'h000;
    else if (wr_en && hit(AVS_ADDRESS, `TPS_OFS_MEM_ADDR))
      mem_addr_r <= wd[11:0];
    else if (wr_en && hit(AVS_ADDRESS, `TPS_OFS_FUNC_DATA))
      mem_addr_r <= mem_addr_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare path
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      sense_m_r <= 8'h00;
      sense_s_r <= 8'h00;
    end
    else
    begin
      sense_m_r <= PIN_SENSE;
      sense_s_r <= sense_m_r;
    end
  end

  assign word = mem[cur_r];
  assign dir_act = word[`TPS_WORD_DIR_SEL] ? dir_b_r : dir_a_r; // R21
  assign mask_act = word[`TPS_WORD_MASK_SEL] ? mask_b_r : mask_a_r; // R22
  // driven pins are never compared
  assign cmp = (sense_s_r ^ word[`TPS_WORD_DATA]) & mask_act & ~dir_act; // R23
  assign raw_fail = |cmp;
  assign fail_masked = raw_fail & ~(sync_r & (cur_r <= sync_addr_r)); // R16

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  tps_period_gen u_period (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .RUN_EN(state_r != TPS_IDLE),
    .EXT_MODE(ext_r),
    .EXT_TRIG(EXT_PERIOD_IN),
    .DIV(div_r),
    .TICK(tick)
  );

  assign top = mem_top(depth_r, chain_r, otf_r);
  assign start_p = wr_en & hit(AVS_ADDRESS, `TPS_OFS_CTRL) & wd[`TPS_CTRL_START];
  assign stop_p = wr_en & hit(AVS_ADDRESS, `TPS_OFS_CTRL) & wd[`TPS_CTRL_STOP];
  assign go = tick & (state_r != TPS_IDLE) & ~stop_p;
  assign in_match = state_r == TPS_MATCH;
  assign at_last = cur_r == last_r;
  assign at_end = cur_r == ke_r;
  assign at_begin = cur_r == jb_r;
  assign br_fail = go & (state_r == TPS_RUN) & fail_masked & (cur_r > ignore_r); // R08
  assign br_mexp = go & in_match & raw_fail & (match_tmr_r >= match_lim_r); // R14
  assign br_mpass = go & in_match & ~raw_fail; // R13
  // loop-end is tested before last address in continuous or match mode only; with the loops kept apart the
  // two never coincide, so the order only matters for a bad setup
  assign br_cont = go & at_end & (cont_r | in_match) & ~br_fail & ~br_mexp & ~br_mpass; // R05
  assign br_mom = br_cont & cont_r & mom_r & ~in_match; // R12
  assign br_last = go & at_last & ~br_fail & ~br_mexp & ~br_mpass & ~br_cont;
  assign br_minor = go & at_end & ~at_last & (minor_r != 13'h0000) & ~br_fail & ~br_mexp
                    & ~br_mpass & ~br_cont; // R25
  assign br_exit = go & at_end & ~at_last & (minor_r == 13'h0000) & ~br_fail & ~br_mexp
                   & ~br_mpass & ~br_cont;
  assign mom_clr = br_mom;
  assign match_clr = br_mpass;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      state_r <= TPS_IDLE;
      cur_r <= 12'h000;
      minor_r <= 13'h0000;
      major_r <= 13'h0000;
      {pass_r, fail_r, mfail_r} <= 3'h0;
    end
    else if (start_p && state_r == TPS_IDLE)
    begin
      state_r <= TPS_RUN;
      cur_r <= start_r; // R01
      minor_r <= minor_cfg_r;
      major_r <= major_cfg_r;
      {pass_r, fail_r, mfail_r} <= 3'h0;
    end
    else if (stop_p)
      state_r <= TPS_IDLE;
    else if (go)
    begin
      if (br_fail)
      begin
        state_r <= TPS_IDLE;
        fail_r <= 1'b1;
      end
      else if (br_mexp)
      begin
        state_r <= TPS_IDLE;
        mfail_r <= 1'b1; // R14
      end
      else if (br_mpass)
      begin
        state_r <= TPS_RUN;
        cur_r <= 12'h000; // R13
      end
      else if (br_cont)
        cur_r <= br_mom ? step(cur_r, top) : jb_r; // R09 R11
      else if (br_last)
      begin
        if (major_r == 13'h0000)
        begin
          state_r <= TPS_IDLE;
          pass_r <= 1'b1; // R07
        end
        else
        begin
          major_r <= major_r - 13'h0001; // R02 R25
          cur_r <= 12'h000;
        end
      end
      else if (br_minor)
      begin
        minor_r <= minor_r - 13'h0001; // R03
        cur_r <= jb_r;
      end
      else
      begin
        if (br_exit)
          minor_r <= minor_cfg_r;
        cur_r <= step(cur_r, top); // R01 R06
      end
      if (match_r && state_r == TPS_RUN && at_begin && !br_fail)
        state_r <= TPS_MATCH; // R13
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      match_tmr_r <= 16'h0000;
    else if (!in_match)
      match_tmr_r <= 16'h0000;
    else if (go)
      match_tmr_r <= match_tmr_r + 16'h0001; // R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // fail capture and pin outputs
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      fail_reg_r <= 8'h00;
      fail_buf_r <= 8'h00;
      fail_col_r <= 1'b0;
    end
    else
    begin
      fail_col_r <= go & raw_fail;
      if (go)
        fail_reg_r <= cmp; // R19
      if (fail_col_r)
        fail_buf_r <= fail_reg_r; // R19
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      PIN_DRIVE <= 8'h00;
      PIN_DRIVE_EN <= 8'h00;
      SYNC_OUT <= 1'b0;
    end
    else
    begin
      PIN_DRIVE <= word[`TPS_WORD_DATA] & dir_act;
      PIN_DRIVE_EN <= (state_r != TPS_IDLE) ? dir_act : 8'h00;
      SYNC_OUT <= go & sync_r & (cur_r == sync_addr_r); // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_step;
    @(posedge CLK) disable iff (!RESET_N)
    go & ~br_fail & ~br_mexp & ~br_mpass & ~br_cont & ~br_last & ~br_minor & (cur_r != top)
    |=> cur_r == $past(cur_r) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("address did not advance"); // R01

  property p_major;
    @(posedge CLK) disable iff (!RESET_N)
    br_last & (major_r != 13'h0000) |=>
      (cur_r == 12'h000) && (major_r == $past(major_r) - 13'h0001);
  endproperty
  a_major: assert property (p_major) else $error("major loop branch wrong"); // R02

  property p_minor;
    @(posedge CLK) disable iff (!RESET_N)
    br_minor |=> (cur_r == $past(jb_r)) && (minor_r == $past(minor_r) - 13'h0001);
  endproperty
  a_minor: assert property (p_minor) else $error("minor loop branch wrong"); // R03

  property p_wrap;
    @(posedge CLK) disable iff (!RESET_N)
    go & (cur_r == top) & ~at_last & ~at_end & ~br_fail & ~in_match |=> cur_r == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at top of memory"); // R06

  property p_pass;
    @(posedge CLK) disable iff (!RESET_N)
    br_last & (major_r == 13'h0000) |=> (state_r == TPS_IDLE) && pass_r && !fail_r;
  endproperty
  a_pass: assert property (p_pass) else $error("pass stop missing"); // R07

  property p_fail;
    @(posedge CLK) disable iff (!RESET_N)
    br_fail |=> (state_r == TPS_IDLE) && fail_r && (cur_r == $past(cur_r))
      ##1 fail_buf_r == $past(fail_reg_r);
  endproperty
  a_fail: assert property (p_fail) else $error("fail stop wrong"); // R08

  property p_cont;
    @(posedge CLK) disable iff (!RESET_N)
    br_cont & ~br_mom & cont_r |=> (cur_r == $past(jb_r)) && $stable(minor_r) && $stable(major_r);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous loop disturbed"); // R09

  property p_mom;
    @(posedge CLK) disable iff (!RESET_N)
    br_mom & (cur_r != top) |=> (cur_r == $past(cur_r) + 12'h001) && !mom_r && !cont_r;
  endproperty
  a_mom: assert property (p_mom) else $error("momentary exit wrong"); // R11

  property p_match_exit;
    @(posedge CLK) disable iff (!RESET_N)
    br_mpass |=> (state_r == TPS_RUN) && (cur_r == 12'h000) && !match_r;
  endproperty
  a_match_exit: assert property (p_match_exit) else $error("match exit wrong"); // R13

  property p_match_tmo;
    @(posedge CLK) disable iff (!RESET_N)
    br_mexp |=> (state_r == TPS_IDLE) && mfail_r && !pass_r;
  endproperty
  a_match_tmo: assert property (p_match_tmo) else $error("match timeout not reported"); // R14

  property p_sync;
    @(posedge CLK) disable iff (!RESET_N)
    go & sync_r & (cur_r == sync_addr_r) |=> SYNC_OUT ##1 !SYNC_OUT;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse wrong"); // R15

  property p_sync_inh;
    @(posedge CLK) disable iff (!RESET_N)
    go & sync_r & (cur_r <= sync_addr_r) |=> !fail_r;
  endproperty
  a_sync_inh: assert property (p_sync_inh) else $error("failure not inhibited"); // R16
endmodule : tps_sequencer

// *** sim/tps_dut_model.sv ***
`timescale 1ns/100ps
// far-end device: driven pins read back as driven, others show the bench's chosen level
module tps_dut_model (
  input tps_pkg::tps_pins_t drive,
  input tps_pkg::tps_pins_t drive_en,
  input tps_pkg::tps_pins_t out_val,
  output tps_pkg::tps_pins_t sense
);
  import tps_pkg::*;
  // undriven outputs never echo the stimulus, so a turned-round compare shows up
  assign sense = (drive & drive_en) | (out_val & ~drive_en);
endmodule : tps_dut_model

// *** sim/test_tps_sequencer.sv ***
`timescale 1ns/100ps
`include "tps_consts.svh"
module test_tps_sequencer;
  import tps_pkg::*;
  localparam logic [31:0] DEP = 32'h0800;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  tps_pins_t pin_sense;
  tps_pins_t pin_drive;
  tps_pins_t pin_drive_en;
  tps_pins_t out_val = 8'h00;
  logic ext_period_in = 1'b0;
  logic sync_out;
  logic [31:0] rd;
  logic [31:0] w;
  logic [12:0] m;
  logic [12:0] n;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int syncs = 0;
  int s0;
  integer seed = 32'hcd3d;
  ////////////////////////////////////////////////////////////////////////////
  tps_sequencer uut (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PIN_SENSE(pin_sense), .PIN_DRIVE(pin_drive), .PIN_DRIVE_EN(pin_drive_en),
    .EXT_PERIOD_IN(ext_period_in), .SYNC_OUT(sync_out));
  tps_dut_model far_end (.drive(pin_drive), .drive_en(pin_drive_en), .out_val(out_val),
    .sense(pin_sense));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #25 clk = ~clk;
  end
  // one-cycle pulses, so counting at every edge sees each once
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (sync_out === 1'b1)
      syncs <= syncs + 1;
    if (cycles == 60000)
    begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // entered right after a rising edge; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rc
  task automatic go(input logic [31:0] s, input logic [31:0] l, input logic [31:0] c);
    bus(1'b1, `TPS_OFS_START, s);
    bus(1'b1, `TPS_OFS_LAST, l);
    s0 = syncs;
    bus(1'b1, `TPS_OFS_CTRL, c | 32'h1);
  endtask : go
  task automatic fin();
    do bus(1'b0, `TPS_OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : fin
  function automatic logic [31:0] exp_sync(input logic [12:0] mc, input logic [12:0] nc);
    return (32'(mc) + 32'h1) * (32'(nc) + 32'h1);
  endfunction : exp_sync
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rc(`TPS_OFS_STATUS, 32'h0, "status after reset");
    rc(`TPS_OFS_PERIOD, `TPS_DIV_RST, "divider after reset");
    bus(1'b1, 8'hfc, 32'hffff);
    rc(8'hfc, 32'h0, "unmapped read");
    w = $random(seed);
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h20);
    bus(1'b1, `TPS_OFS_FUNC_DATA, w);
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h20);
    rc(`TPS_OFS_FUNC_DATA, {22'h0, w[9:0]}, "pattern word");
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h0);
    repeat (8) bus(1'b1, `TPS_OFS_FUNC_DATA, 32'h0);
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'hfe);
    repeat (2) bus(1'b1, `TPS_OFS_FUNC_DATA, 32'h0);
    bus(1'b1, `TPS_OFS_PERIOD, 32'h1);
    go(0, 1, DEP);
    fin();
    chk("status plain run", 32'h2, rd);
    rc(`TPS_OFS_CUR_ADDR, 32'h1, "end address");
    $display("plain run done");
    // minor loop wholly inside the major loop
    bus(1'b1, `TPS_OFS_LOOP_BEGIN, 32'h1);
    bus(1'b1, `TPS_OFS_LOOP_END, 32'h2);
    bus(1'b1, `TPS_OFS_SYNC_ADDR, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      m = (k == 0) ? 13'h1000 : 13'($random(seed) & 3);
      n = 13'($random(seed) & 3);
      bus(1'b1, `TPS_OFS_MINOR_CNT, 32'(m));
      bus(1'b1, `TPS_OFS_MAJOR_CNT, 32'(n));
      go(0, 3, DEP | 32'h10);
      fin();
      chk("status loop run", 32'h2, rd);
      chk("sync pulses", exp_sync(m, n), syncs - s0);
    end
    $display("loop runs done");
    bus(1'b1, `TPS_OFS_MASK_A, 32'h03);
    bus(1'b1, `TPS_OFS_IGNORE, 32'h1);
    out_val <= 8'h05;
    go(0, 3, DEP);
    fin();
    chk("status on fail", 32'h4, rd);
    rc(`TPS_OFS_CUR_ADDR, 32'h2, "failing address");
    rc(`TPS_OFS_FAIL_REG, 32'h1, "fail pattern");
    rc(`TPS_OFS_FAIL_BUF, 32'h1, "fail buffer");
    bus(1'b1, `TPS_OFS_IGNORE, 32'h0);
    bus(1'b1, `TPS_OFS_SYNC_ADDR, 32'h2);
    go(0, 3, DEP | 32'h10);
    fin();
    rc(`TPS_OFS_CUR_ADDR, 32'h3, "first unsuppressed fail");
    $display("fail runs done");
    out_val <= 8'h00;
    bus(1'b1, `TPS_OFS_MINOR_CNT, 32'h0);
    go(0, 3, DEP | 32'h2);
    repeat (40) @(posedge clk);
    rc(`TPS_OFS_STATUS, 32'h1, "still looping");
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h28);
    bus(1'b1, `TPS_OFS_FUNC_DATA, ~w);
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h28);
    rc(`TPS_OFS_FUNC_DATA, {22'h0, ~w[9:0]}, "word while looping");
    bus(1'b1, `TPS_OFS_CTRL, DEP | 32'h6);
    fin();
    chk("status after momentary", 32'h2, rd);
    rc(`TPS_OFS_CTRL, DEP, "mode bits cleared");
    $display("continuous runs done");
    bus(1'b1, `TPS_OFS_MATCH_LIM, 32'h14);
    bus(1'b1, `TPS_OFS_IGNORE, 32'hfff);
    out_val <= 8'h01;
    go(0, 3, DEP | 32'h8);
    fin();
    chk("match timeout", 32'h1, 32'(rd[3]));
    out_val <= 8'h00;
    go(0, 3, DEP | 32'h8);
    fin();
    chk("status match pass", 32'h2, rd);
    rc(`TPS_OFS_CTRL, DEP, "match bit cleared");
    $display("match runs done");
    // one major pass only, so the trigger pulses and the wrap count below suffice
    bus(1'b1, `TPS_OFS_MAJOR_CNT, 32'h0);
    go(0, 1, DEP | 32'h20);
    repeat (20) @(posedge clk);
    rc(`TPS_OFS_STATUS, 32'h1, "waits for trigger");
    repeat (4)
    begin
      ext_period_in <= 1'b1;
      repeat (4) @(posedge clk);
      ext_period_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    fin();
    chk("status ext run", 32'h2, rd);
    bus(1'b1, `TPS_OFS_SYNC_ADDR, 32'h0);
    go(32'hfe, 1, 32'h10);
    fin();
    chk("wrap sync pulses", 32'h1, syncs - s0);
    // word selecting direction b and mask b; driven pins drop out of the compare
    bus(1'b1, `TPS_OFS_MEM_ADDR, 32'h4);
    bus(1'b1, `TPS_OFS_FUNC_DATA, 32'h3a5);
    bus(1'b1, `TPS_OFS_DIR_B, 32'hf0);
    bus(1'b1, `TPS_OFS_MASK_B, 32'h3c);
    go(4, 4, DEP);
    fin();
    rc(`TPS_OFS_FAIL_REG, 32'h04, "mask and dir select");
    chk("drive data", 32'ha0, 32'(pin_drive));
    chk("drive enable idle", 32'h0, 32'(pin_drive_en));
    $display("ext and wrap runs done");
    conclude();
  end
endmodule : test_tps_sequencer
